// ===== hdl/dqr_pkg.sv
// constants, latency tables and state types for the four-lane double-rate read
// assumes both link ends and their bench share these names
//
// Overview of operation
// - host uses read only with quad enabled
// - opcode EDh takes three address bytes normally
// - opcode EDh takes four bytes in wide mode
// - opcode EEh always takes four address bytes
// - address moves one nibble per clock edge
// - data leaves one nibble per clock edge
// - host clock never above 80 MHz
// - dummy cycles follow mode, lines ignored
// - host floats lines during dummy with preamble
// - dummy count comes from latency code table
// - neither table counts the mode cycle
// - complementary mode nibbles enter continuous mode
// - other mode nibbles leave continuous mode
// - short select pulse leaves continuous mode
// - address steps by one per byte
// - top address wraps to zero
// - host keeps select low through mode, dummy
// - hold function ignored during this read
// - preamble fills last four dummy cycles
// - host releases lines before the preamble
// - same pattern on every active line
// - host checks preamble against the pattern
package dqr_pkg;

    localparam logic [7:0] OP_READ_FLEX       = 8'hED;
    localparam logic [7:0] OP_READ_WIDE       = 8'hEE;
    localparam logic [2:0] ADDR_BYTES_NARROW  = 3'h3;
    localparam logic [2:0] ADDR_BYTES_WIDE    = 3'h4;
    localparam logic [2:0] CMD_LAST_BIT       = 3'h7;
    localparam logic [4:0] MODE_LAST_EDGE     = 5'h01;
    localparam logic [4:0] PREAMBLE_EDGES     = 5'h08;
    localparam logic [3:0] SHORT_FRAME_CYCLES = 4'h8;
    localparam logic [7:0] PREAMBLE_DEFAULT   = 8'h34;
    localparam logic [3:0] NIBBLE_ALL         = 4'hF;
    localparam logic [3:0] NIBBLE_LANE0       = 4'h1;

    // time base: system clock, bench link clock and the command's top rate
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SCK_PERIOD_NS  = 800;
    localparam int SCK_MAX_MHZ    = 80;
    localparam int SCK_MIN_PER_PS = (1000000 + SCK_MAX_MHZ - 1) / SCK_MAX_MHZ;
    localparam int SCK_HALF_CLKS  = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                    / (2 * CLK_PERIOD_NS);

    // dummy cycles per latency code, one table per part variant
    localparam logic [3:0] LAT_FAST [4] = '{4'h5, 4'h6, 4'h7, 4'h8};
    localparam logic [3:0] LAT_ENH  [4] = '{4'h4, 4'h5, 4'h6, 4'h7};

    function automatic logic [3:0] dummy_cycles(input logic       enhanced,
                                                input logic [1:0] code);
        return enhanced ? LAT_ENH[code] : LAT_FAST[code];
    endfunction

    typedef enum logic [6:0] {
        DEV_IDLE  = 7'h01,
        DEV_CMD   = 7'h02,
        DEV_ADDR  = 7'h04,
        DEV_MODE  = 7'h08,
        DEV_DUMMY = 7'h10,
        DEV_DATA  = 7'h20,
        DEV_SKIP  = 7'h40
    } dqr_dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE = 3'h1,
        HST_RUN  = 3'h2,
        HST_END  = 3'h4
    } dqr_hst_state_t;

endpackage

// ===== hdl/dqr_if.sv
// link between flash controller and flash device: clock, select, four lanes
// assumes lanes are pulled high when neither end drives them
`timescale 1ns/1ps
interface dqr_if;
    logic       sck;
    logic       cs_n;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dev_io_oe[i])
                io[i] = dev_io_o[i];
            else if (host_io_oe[i])
                io[i] = host_io_o[i];
            else
                io[i] = 1'b1;
        end
    end

    modport device (input sck, input cs_n, input io, output dev_io_o, output dev_io_oe);
    modport host (output sck, output cs_n, output host_io_o, output host_io_oe, input io);
endinterface

// ===== hdl/dqr_device.sv
// flash device end: decodes the double-rate quad read and streams its array
// assumes the host makes sck and select; both are sampled by clock
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module dqr_device #(
    parameter int   MEM_BYTES              = 256,
    parameter bit   LATENCY_TABLE_ENHANCED = 1'b0,
    localparam int  AW                     = $clog2(MEM_BYTES)
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          ce,
    dqr_if.device              link,
    input  wire logic          quad_enable,
    input  wire logic          wide_address_mode,
    input  wire logic [1:0]    latency_code,
    input  wire logic          training_preamble,
    input  wire logic [7:0]    training_pattern,
    input  wire logic          mem_we,
    input  wire logic [AW-1:0] mem_waddr,
    input  wire logic [7:0]    mem_wdata,
    output logic               continuous_mode,
    output logic               busy
);

    localparam logic [AW-1:0] MEM_LAST = AW'(MEM_BYTES - 1);

    dqr_pkg::dqr_dev_state_t state;

    logic [7:0]    mem [MEM_BYTES];
    logic [2:0]    sck_sync;
    logic [1:0]    cs_sync;
    logic [3:0]    io_q1;
    logic [3:0]    io_q2;
    logic          cs_prev;
    logic [7:0]    opcode;
    logic [31:0]   addr_sh;
    logic [7:0]    mode_sh;
    logic [2:0]    nbytes;
    logic [4:0]    cnt;
    logic [3:0]    rise_cnt;
    logic [AW-1:0] addr;
    logic          low_half;
    logic [3:0]    io_out;
    logic [3:0]    io_oe;
    logic [4:0]    dummy_edges;
    logic [4:0]    addr_last;
    logic [4:0]    next_cnt;
    logic          edge_r;
    logic          edge_any;
    logic          cs_high;
    logic          mode_comp;

    assign edge_r   = sck_sync[1] & ~sck_sync[2];
    assign edge_any = sck_sync[1] ^ sck_sync[2];
    assign cs_high  = cs_sync[1];
    assign next_cnt = cnt + 5'h01;

    // latency from the code field; every table entry leaves room for the four-cycle preamble
    assign dummy_edges = {1'b0, dqr_pkg::dummy_cycles(LATENCY_TABLE_ENHANCED,
                                                      latency_code)} << 1;
    assign addr_last   = ({2'h0, nbytes} << 1) - 5'h01;
    assign mode_comp   = (mode_sh[7:4] == ~mode_sh[3:0]);

    assign link.dev_io_o  = io_out;
    assign link.dev_io_oe = io_oe;
    assign busy           = (state != dqr_pkg::DEV_IDLE);

    // preamble drives the last eight dummy edges, i.e. four cycles
    function automatic logic pre_on(input logic [4:0] k);
        return training_preamble && (k >= dummy_edges - dqr_pkg::PREAMBLE_EDGES);
    endfunction

    function automatic logic [3:0] pre_nibble(input logic [4:0] k);
        logic [4:0] idx;
        idx = dummy_edges - 5'h01 - k;
        return {4{training_pattern[idx[2:0]]}};
    endfunction

    // link inputs cross into clock through two flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_sync <= 3'h0;
            cs_sync  <= 2'h3;
            io_q1    <= 4'h0;
            io_q2    <= 4'h0;
            cs_prev  <= 1'b1;
        end else if (ce) begin
            sck_sync <= {sck_sync[1:0], link.sck};
            cs_sync  <= {cs_sync[0], link.cs_n};
            io_q1    <= link.io;
            io_q2    <= io_q1;
            cs_prev  <= cs_sync[1];
        end
    end

    // array contents are loaded from the user side
    always_ff @(posedge clock) begin
        if (ce && mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // continuous mode is decided when select rises
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            continuous_mode <= 1'b0;
        end else if (ce && cs_high && !cs_prev) begin
            if (state == dqr_pkg::DEV_DUMMY || state == dqr_pkg::DEV_DATA) begin
                continuous_mode <= mode_comp;
            end else if (continuous_mode && state == dqr_pkg::DEV_ADDR &&
                         rise_cnt <= dqr_pkg::SHORT_FRAME_CYCLES) begin
                continuous_mode <= 1'b0;
            end
        end
    end

    // rising edges seen in this frame, saturating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rise_cnt <= 4'h0;
        end else if (ce) begin
            if (cs_high)
                rise_cnt <= 4'h0;
            else if (edge_r && rise_cnt != 4'hF)
                rise_cnt <= rise_cnt + 4'h1;
        end
    end

    // command sequencer and lane drivers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state    <= dqr_pkg::DEV_IDLE;
            opcode   <= 8'h00;
            addr_sh  <= 32'h0000_0000;
            mode_sh  <= 8'h00;
            nbytes   <= dqr_pkg::ADDR_BYTES_NARROW;
            cnt      <= 5'h00;
            addr     <= '0;
            low_half <= 1'b0;
            io_out   <= 4'h0;
            io_oe    <= 4'h0;
        end else if (ce) begin
            if (cs_high) begin
                state <= dqr_pkg::DEV_IDLE;
                io_oe <= 4'h0;
            end else begin
                unique case (state)
                    dqr_pkg::DEV_IDLE: begin
                        cnt     <= 5'h00;
                        addr_sh <= 32'h0000_0000;
                        // continuous mode starts straight with the address
                        state   <= continuous_mode ? dqr_pkg::DEV_ADDR
                                                   : dqr_pkg::DEV_CMD;
                    end
                    dqr_pkg::DEV_CMD: begin
                        if (edge_r) begin
                            opcode <= {opcode[6:0], io_q2[0]};
                        end
                        // falling edge after the last bit closes the opcode
                        if (edge_any) begin
                            cnt <= next_cnt;
                            if (cnt[3:0] == {dqr_pkg::CMD_LAST_BIT, 1'b1}) begin
                                cnt <= 5'h00;
                                if (!quad_enable) begin
                                    state <= dqr_pkg::DEV_SKIP;
                                end else if (opcode == dqr_pkg::OP_READ_WIDE) begin
                                    nbytes <= dqr_pkg::ADDR_BYTES_WIDE;
                                    state  <= dqr_pkg::DEV_ADDR;
                                end else if (opcode == dqr_pkg::OP_READ_FLEX) begin
                                    nbytes <= wide_address_mode
                                              ? dqr_pkg::ADDR_BYTES_WIDE
                                              : dqr_pkg::ADDR_BYTES_NARROW;
                                    state  <= dqr_pkg::DEV_ADDR;
                                end else begin
                                    state <= dqr_pkg::DEV_SKIP;
                                end
                            end
                        end
                    end
                    dqr_pkg::DEV_ADDR: begin
                        if (edge_any) begin
                            addr_sh <= {addr_sh[27:0], io_q2};
                            cnt     <= next_cnt;
                            if (cnt == addr_last) begin
                                cnt   <= 5'h00;
                                state <= dqr_pkg::DEV_MODE;
                            end
                        end
                    end
                    dqr_pkg::DEV_MODE: begin
                        if (edge_any) begin
                            mode_sh <= {mode_sh[3:0], io_q2};
                            cnt     <= next_cnt;
                            if (cnt == dqr_pkg::MODE_LAST_EDGE) begin
                                cnt   <= 5'h00;
                                addr  <= addr_sh[AW-1:0];
                                state <= dqr_pkg::DEV_DUMMY;
                                // lane values are ignored from here on
                                io_oe  <= pre_on(5'h00) ? dqr_pkg::NIBBLE_ALL : 4'h0;
                                io_out <= pre_nibble(5'h00);
                            end
                        end
                    end
                    dqr_pkg::DEV_DUMMY: begin
                        if (edge_any) begin
                            cnt <= next_cnt;
                            if (next_cnt == dummy_edges) begin
                                cnt      <= 5'h00;
                                state    <= dqr_pkg::DEV_DATA;
                                low_half <= 1'b1;
                                io_oe    <= dqr_pkg::NIBBLE_ALL;
                                io_out   <= mem[addr][7:4];
                            end else begin
                                io_oe  <= pre_on(next_cnt) ? dqr_pkg::NIBBLE_ALL
                                                           : 4'h0;
                                io_out <= pre_nibble(next_cnt);
                            end
                        end
                    end
                    dqr_pkg::DEV_DATA: begin
                        // hold never pauses this stream
                        if (edge_any) begin
                            low_half <= ~low_half;
                            if (low_half) begin
                                io_out <= mem[addr][3:0];
                                addr   <= (addr == MEM_LAST) ? '0
                                                             : addr + 1'b1;
                            end else begin
                                io_out <= mem[addr][7:4];
                            end
                        end
                    end
                    dqr_pkg::DEV_SKIP: begin
                        io_oe <= 4'h0;
                    end
                endcase
            end
        end
    end

endmodule

// ===== hdl/dqr_host.sv
// controller end: clocks out one double-rate quad read and collects the bytes
// assumes a device on the other side of dqr_if with matching latency
`timescale 1ns/1ps
module dqr_host #(
    parameter int SCK_HALF = dqr_pkg::SCK_HALF_CLKS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    dqr_if.host              link,
    input  wire logic        start,
    input  wire logic        quad_enable,
    input  wire logic        use_wide_opcode,
    input  wire logic        wide_address_mode,
    input  wire logic        skip_instruction,
    input  wire logic [31:0] address,
    input  wire logic [7:0]  mode_bits,
    input  wire logic [3:0]  dummy_cycles,
    input  wire logic        training_preamble,
    input  wire logic [7:0]  training_pattern,
    input  wire logic [15:0] byte_count,
    output logic             busy,
    output logic             done,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             training_ok
);

    localparam logic [7:0] PH_LAST = 8'(SCK_HALF - 1);
    localparam logic [7:0] PH_MID  = 8'(SCK_HALF / 2 - 1);

    dqr_pkg::dqr_hst_state_t state;

    logic [7:0]  ph;
    logic [19:0] e;
    logic [19:0] e_addr;
    logic [19:0] e_mode;
    logic [19:0] e_dummy;
    logic [19:0] e_pre;
    logic [19:0] e_data;
    logic [19:0] e_last;
    logic [7:0]  op;
    logic [31:0] addr_sh;
    logic [7:0]  mode_sh;
    logic [7:0]  pat;
    logic        pre_en;
    logic [3:0]  hi;
    logic        wide_addr;
    logic [3:0]  io_q1;
    logic [3:0]  io_q2;
    logic [19:0] e_off;
    logic [19:0] c_edges;
    logic [19:0] a_edges;
    logic [19:0] d_edges;

    assign busy         = (state != dqr_pkg::HST_IDLE);
    assign wide_addr    = wide_address_mode || use_wide_opcode;
    // opcode bits take both edges of a cycle, address bytes two nibble edges
    assign c_edges      = skip_instruction ? 20'h0
                                           : {15'h0, {1'b0, dqr_pkg::CMD_LAST_BIT} + 4'h1, 1'b0};
    assign a_edges      = {16'h0, wide_addr ? dqr_pkg::ADDR_BYTES_WIDE
                                            : dqr_pkg::ADDR_BYTES_NARROW, 1'b0};
    assign d_edges      = {15'h0, dummy_cycles, 1'b0};
    assign e_off        = e - e_pre;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            io_q1 <= 4'h0;
            io_q2 <= 4'h0;
        end else if (ce) begin
            io_q1 <= link.io;
            io_q2 <= io_q1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state            <= dqr_pkg::HST_IDLE;
            ph               <= 8'h00;
            e                <= 20'h0;
            e_addr           <= 20'h0;
            e_mode           <= 20'h0;
            e_dummy          <= 20'h0;
            e_pre            <= 20'h0;
            e_data           <= 20'h0;
            e_last           <= 20'h0;
            op               <= 8'h00;
            addr_sh          <= 32'h0000_0000;
            mode_sh          <= 8'h00;
            pat              <= 8'h00;
            pre_en           <= 1'b0;
            hi               <= 4'h0;
            link.sck         <= 1'b0;
            link.cs_n        <= 1'b1;
            link.host_io_o   <= 4'h0;
            link.host_io_oe  <= 4'h0;
            done             <= 1'b0;
            rd_data          <= 8'h00;
            rd_valid         <= 1'b0;
            training_ok      <= 1'b0;
        end else if (ce) begin
            done     <= 1'b0;
            rd_valid <= 1'b0;
            unique case (state)
                dqr_pkg::HST_IDLE: begin
                    if (start && quad_enable) begin
                        state     <= dqr_pkg::HST_RUN;
                        link.cs_n <= 1'b0;
                        ph        <= 8'h00;
                        e         <= 20'h0;
                        op        <= use_wide_opcode ? dqr_pkg::OP_READ_WIDE
                                                     : dqr_pkg::OP_READ_FLEX;
                        addr_sh   <= wide_addr ? address : {address[23:0], 8'h00};
                        mode_sh   <= mode_bits;
                        pat       <= training_pattern;
                        pre_en    <= training_preamble;
                        training_ok <= training_preamble;
                        e_addr    <= c_edges;
                        e_mode    <= c_edges + a_edges;
                        e_dummy   <= c_edges + a_edges + 20'h2;
                        // device output after edge i is captured two edges later
                        e_pre     <= c_edges + a_edges + 20'h1 + d_edges - 20'h6;
                        e_data    <= c_edges + a_edges + 20'h1 + d_edges + 20'h2;
                        e_last    <= c_edges + a_edges + 20'h2 + d_edges
                                     + {3'h0, byte_count, 1'b0};
                    end
                end
                dqr_pkg::HST_RUN: begin
                    ph <= (ph == PH_LAST) ? 8'h00 : ph + 8'h01;
                    if (ph == PH_MID) begin
                        if (e < e_addr) begin
                            link.host_io_oe <= dqr_pkg::NIBBLE_LANE0;
                            link.host_io_o  <= {3'h0, op[3'(7 - e[4:1])]};
                        end else if (e < e_mode) begin
                            link.host_io_oe <= dqr_pkg::NIBBLE_ALL;
                            link.host_io_o  <= addr_sh[31:28];
                            addr_sh         <= {addr_sh[27:0], 4'h0};
                        end else if (e < e_dummy) begin
                            link.host_io_oe <= dqr_pkg::NIBBLE_ALL;
                            link.host_io_o  <= mode_sh[7:4];
                            mode_sh         <= {mode_sh[3:0], 4'h0};
                        end else begin
                            link.host_io_oe <= 4'h0;
                        end
                    end
                    if (ph == PH_LAST) begin
                        if (pre_en && e >= e_pre && e < e_data &&
                            io_q2 != {4{pat[3'(7 - e_off[2:0])]}}) begin
                            training_ok <= 1'b0;
                        end
                        if (e >= e_data) begin
                            if (e[0] == e_data[0]) begin
                                hi <= io_q2;
                            end else begin
                                rd_data  <= {hi, io_q2};
                                rd_valid <= 1'b1;
                            end
                        end
                        if (e >= e_last) begin
                            // select rises in the same cycle as the last data capture
                            state     <= dqr_pkg::HST_END;
                            link.cs_n <= 1'b1;
                        end else begin
                            // divider keeps sck far below the top rate
                            link.sck <= ~link.sck;
                            e        <= e + 20'h1;
                        end
                    end
                end
                dqr_pkg::HST_END: begin
                    ph <= (ph == PH_LAST) ? 8'h00 : ph + 8'h01;
                    if (ph == PH_LAST) begin
                        state <= dqr_pkg::HST_IDLE;
                        done  <= 1'b1;
                    end
                end
                default: begin
                    state <= dqr_pkg::HST_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== test/dqr_link_props.sv
// link checker: lane enables, select and link clock between the two ends
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ps
module dqr_link_props (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_no_clash; (host_io_oe & dev_io_oe) == 4'h0; endproperty
    a_no_clash: assert property (p_no_clash) else $error("lane driven twice");
    property p_release; $rose(cs_n) |-> ##[1:4] (dev_io_oe == 4'h0); endproperty
    a_release: assert property (p_release) else $error("lanes kept");
    property p_quiet; cs_n [*5] |-> dev_io_oe == 4'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("drive while idle");
    property p_dev_lanes; dev_io_oe == 4'h0 || dev_io_oe == 4'hF; endproperty
    a_dev_lanes: assert property (p_dev_lanes) else $error("partial lanes");
    property p_host_lanes; host_io_oe inside {4'h0, 4'h1, 4'hF}; endproperty
    a_host_lanes: assert property (p_host_lanes) else $error("host lanes");
    property p_sck_rate; $changed(sck) |=> $stable(sck) [*3]; endproperty
    a_sck_rate: assert property (p_sck_rate) else $error("sck too fast");
    property p_frame; $fell(cs_n) |-> !cs_n [*8]; endproperty
    a_frame: assert property (p_frame) else $error("frame cut");
    property p_turn; $rose(dev_io_oe != 4'h0) |-> !cs_n && host_io_oe == 4'h0; endproperty
    a_turn: assert property (p_turn) else $error("turnaround");
endmodule

// ===== test/tb_ddr_quad_io_read.sv
// bench: host and device joined by the link, bytes checked against a copy of the array
// assumes the host makes the link clock from its own clock
`timescale 1ns/1ps
module tb_ddr_quad_io_read;
    logic        clock, rst, start, qe, wop, wam, skip, pre, we, cm, busy, done, rv, tok;
    logic        hrst, dbusy;
    logic [7:0]  mode, pat, wa, wd, rd;
    logic [1:0]  code;
    logic [31:0] addr;
    logic [15:0] cnt;
    logic [7:0]  mem [256];
    logic [7:0]  q [$];
    int          num_errors, checked, cyc;
    logic [31:0] x;
    always #50 clock = ~clock;
    dqr_if lnk ();
    dqr_device dqr_device_i (.clock(clock), .rst(rst), .ce(1'b1), .link(lnk.device),
        .quad_enable(qe), .wide_address_mode(wam), .latency_code(code), .training_preamble(pre),
        .training_pattern(pat), .mem_we(we), .mem_waddr(wa), .mem_wdata(wd),
        .continuous_mode(cm), .busy(dbusy));
    dqr_host dqr_host_i (.clock(clock), .rst(rst | hrst), .ce(1'b1), .link(lnk.host),
        .start(start), .quad_enable(qe), .use_wide_opcode(wop), .wide_address_mode(wam),
        .skip_instruction(skip), .address(addr), .mode_bits(mode),
        .dummy_cycles(dqr_pkg::LAT_FAST[code]), .training_preamble(pre), .training_pattern(pat),
        .byte_count(cnt), .busy(busy), .done(done), .rd_data(rd), .rd_valid(rv),
        .training_ok(tok));
    dqr_link_props dqr_link_props_i (.clock(clock), .rst(rst), .sck(lnk.sck),
        .cs_n(lnk.cs_n), .host_io_oe(lnk.host_io_oe), .dev_io_oe(lnk.dev_io_oe));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // flags: wide opcode, wide address, skip opcode, preamble
    task automatic run(input logic [3:0] f, input logic [31:0] ad, input logic [7:0] m,
                       input logic [1:0] c, input logic [15:0] n, input logic ec);
        int i;
        for (i = 0; i < n; i++)
            q.push_back(mem[8'(ad + i)]);
        @(posedge clock);
        {wop, wam, skip, pre, addr, mode, code, cnt, start} <= {f, ad, m, c, n, 1'b1};
        @(posedge clock);
        start <= 1'b0;
        for (i = 0; i < 4000 && done !== 1'b1; i++)
            @(negedge clock);
        cmp("done", 8'h01, {7'h0, done});
        cmp("training_ok", {7'h0, f[0]}, {7'h0, tok});
        repeat (4) @(negedge clock);
        cmp("continuous_mode", {7'h0, ec}, {7'h0, cm});
        cmp("bytes left", 8'h00, 8'(q.size()));
    endtask
    always @(negedge clock) begin
        if (rv === 1'b1) begin
            if (q.size() == 0)
                cmp("extra byte", 8'h00, 8'hFF);
            else
                cmp("rd_data", q.pop_front(), rd);
        end
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {clock, rst, qe, num_errors, checked, cyc, x} = {3'h3, 96'h0, 32'h3};
        {hrst, start, wop, wam, skip, pre, we, mode, wa, wd, code, addr, cnt} = '0;
        pat = 8'h34;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 256; k++) begin
            @(posedge clock);
            x = xs(x);
            mem[k] = x[7:0];
            {we, wa, wd} <= {1'b1, 8'(k), x[7:0]};
        end
        @(posedge clock);
        we <= 1'b0;
        run(4'h0, 32'h00AB_CD10, 8'h00, 2'h0, 16'h4, 1'b0);
        run(4'h4, 32'h1234_56FE, 8'h00, 2'h1, 16'h4, 1'b0);
        run(4'h9, 32'h89AB_CDF0, 8'hA5, 2'h2, 16'h3, 1'b1);
        run(4'hB, 32'h0000_0080, 8'h5A, 2'h3, 16'h2, 1'b1);
        run(4'h6, 32'h0000_00FF, 8'h00, 2'h0, 16'h2, 1'b0);
        run(4'h8, 32'h0000_0040, 8'h5A, 2'h1, 16'h2, 1'b1);
        // continuous frame cut by a host reset after three rising edges
        @(posedge clock);
        {wop, skip, start} <= 3'h7;
        @(posedge clock);
        start <= 1'b0;
        repeat (25) @(posedge clock);
        @(negedge clock);
        cmp("device busy", 8'h01, {7'h0, dbusy});
        @(posedge clock);
        hrst <= 1'b1;
        @(posedge clock);
        hrst <= 1'b0;
        repeat (8) @(negedge clock);
        cmp("short frame", 8'h00, {7'h0, cm});
        cmp("device idle", 8'h00, {7'h0, dbusy});
        run(4'h1, 32'h0000_0033, 8'h00, 2'h3, 16'h5, 1'b0);
        @(posedge clock);
        {qe, start} <= 2'h1;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        cmp("refused busy", 8'h00, {7'h0, busy});
        report_and_stop();
    end
endmodule
